// [rtl/acrpr_regs.sv]
// register bank for sampling-clock and sync-reference receivers, supply
// noise suppression, sync edge status, full-scale range and power mode 1.
// assumes a mode-0 serial port far slower than core_clk (sclk <= 4 MHz).
`timescale 1ns/1ps
module acrpr_regs
    import acrpr_pkg::*;
(
    input wire logic core_clk, // 40 MHz core clock
    input wire logic rstn, // async reset, active low
    input wire logic spi_sclk, // serial port clock pin
    input wire logic spi_cs_n, // serial port select pin, active low
    input wire logic spi_sdi, // serial data in pin
    output logic spi_sdo, // serial data out
    output logic spi_sdo_oe_n, // sdo enable, low while driving
    input wire logic sync_ref_in, // sync reference receiver output
    input wire logic [23:0] sync_edge_position_in, // edge detector result
    output logic sampling_clock_pecl_input_en, // sampling clock pecl mode
    output logic sync_ref_pecl_input_en, // sync ref pecl mode
    output logic sync_ref_invert, // sync ref inversion enable
    output logic sync_ref_aligned, // sync ref after polarity
    output logic analog_rail_noise_suppress_en, // analog rail suppression
    output logic clock_rail_noise_suppress_en, // clock rail suppression
    output logic [3:0] sync_delay_select, // chosen sync sample delay
    output logic [15:0] full_scale_range, // full-scale range code
    output logic [7:0] power_mode_code_1, // power mode code
    output logic low_power_mode_active // code selects low power
);

    acrpr_state_s s;
    acrpr_state_s n;
    logic rise;
    logic fall;
    logic wr_en;
    logic [14:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_byte;

    function automatic logic [7:0] read_byte(input acrpr_state_s st,
                                             input logic [14:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a == ACRPR_OFS_SYNC_CTRL) begin
            r = st.sync_ctrl;
        end else if (a == ACRPR_OFS_CLK_IN) begin
            r = st.clk_in;
        end else if (a == ACRPR_OFS_SUPPLY) begin
            r = st.supply;
        end else if (a == ACRPR_OFS_EDGE_B0) begin
            r = st.edge_pos[7:0];
        end else if (a == ACRPR_OFS_EDGE_B1) begin
            r = st.edge_pos[15:8];
        end else if (a == ACRPR_OFS_EDGE_B2) begin
            r = st.edge_pos[23:16];
        end else if (a == ACRPR_OFS_FSR_LO) begin
            r = st.fsr[7:0];
        end else if (a == ACRPR_OFS_FSR_HI) begin
            r = st.fsr[15:8];
        end else if (a == ACRPR_OFS_PWR1) begin
            r = st.pwr1;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        n = s;
        wr_en = 1'b0;
        wr_addr = s.addr;
        wr_data = {s.in_shift[6:0], s.sdi_s2};
        rise = s.sclk_s2 & ~s.sclk_s3;
        fall = ~s.sclk_s2 & s.sclk_s3;
        rd_byte = read_byte(s, s.addr);
        n.sclk_s1 = spi_sclk;
        n.sclk_s2 = s.sclk_s1;
        n.sclk_s3 = s.sclk_s2;
        n.cs_n_s1 = spi_cs_n;
        n.cs_n_s2 = s.cs_n_s1;
        n.sdi_s1 = spi_sdi;
        n.sdi_s2 = s.sdi_s1;
        n.sref_s1 = sync_ref_in;
        n.sref_s2 = s.sref_s1;
        // detector owns the status; serial writes never reach it
        n.edge_pos = sync_edge_position_in;
        n.sref_aligned = s.sref_s2 ^ s.clk_in[ACRPR_BIT_SREF_INV];
        if (s.cs_n_s2) begin
            n.hdr_done = 1'b0;
            n.hdr_cnt = 4'h0;
            n.bit_cnt = 3'h0;
            n.sdo_drive = 1'b0;
        end else if (rise) begin
            if (!s.hdr_done) begin
                n.hdr_shift = {s.hdr_shift[14:0], s.sdi_s2};
                n.hdr_cnt = s.hdr_cnt + 4'h1;
                if (s.hdr_cnt == ACRPR_HDR_LAST) begin
                    n.hdr_done = 1'b1;
                    n.rd = s.hdr_shift[ACRPR_HDR_RD_BIT];
                    n.addr = {s.hdr_shift[13:0], s.sdi_s2};
                    n.bit_cnt = 3'h0;
                end
            end else begin
                n.in_shift = wr_data;
                n.bit_cnt = s.bit_cnt + 3'h1;
                if (s.bit_cnt == ACRPR_BYTE_LAST) begin
                    wr_en = ~s.rd;
                    // streaming walks upward through the byte map
                    n.addr = s.addr + 15'h0001;
                end
            end
        end else if (fall && s.hdr_done && s.rd) begin
            n.sdo_drive = 1'b1;
            if (s.bit_cnt == 3'h0) begin
                n.sdo = rd_byte[7];
                n.out_shift = {rd_byte[6:0], 1'b0};
            end else begin
                n.sdo = s.out_shift[7];
                n.out_shift = {s.out_shift[6:0], 1'b0};
            end
        end
        // reserved bits stored as written; unmapped writes dropped
        if (wr_en) begin
            if (wr_addr == ACRPR_OFS_SYNC_CTRL) begin
                n.sync_ctrl = wr_data;
            end else if (wr_addr == ACRPR_OFS_CLK_IN) begin
                n.clk_in = wr_data;
            end else if (wr_addr == ACRPR_OFS_SUPPLY) begin
                n.supply = wr_data;
            end else if (wr_addr == ACRPR_OFS_FSR_LO) begin
                n.fsr[7:0] = wr_data;
            end else if (wr_addr == ACRPR_OFS_FSR_HI) begin
                n.fsr[15:8] = wr_data;
            end else if (wr_addr == ACRPR_OFS_PWR1) begin
                n.pwr1 = wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.cs_n_s1 <= 1'b1;
            s.cs_n_s2 <= 1'b1;
            s.sync_ctrl <= ACRPR_RST_SYNC_CTRL;
            s.clk_in <= ACRPR_RST_CLK_IN;
            s.supply <= ACRPR_RST_SUPPLY;
            s.edge_pos <= ACRPR_RST_EDGE;
            s.fsr <= ACRPR_RST_FSR;
            s.pwr1 <= ACRPR_RST_PWR1;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign spi_sdo = s.sdo;
    assign spi_sdo_oe_n = ~s.sdo_drive;
    assign sampling_clock_pecl_input_en = s.clk_in[ACRPR_BIT_CLK_PECL];
    assign sync_ref_pecl_input_en = s.clk_in[ACRPR_BIT_SREF_PECL];
    assign sync_ref_invert = s.clk_in[ACRPR_BIT_SREF_INV];
    assign sync_ref_aligned = s.sref_aligned;
    assign analog_rail_noise_suppress_en = s.supply[ACRPR_BIT_ANA_NS];
    assign clock_rail_noise_suppress_en = s.supply[ACRPR_BIT_CLK_NS];
    assign sync_delay_select = s.sync_ctrl[ACRPR_SEL_MSB:0];
    assign full_scale_range = s.fsr;
    assign power_mode_code_1 = s.pwr1;
    assign low_power_mode_active = (s.pwr1 == ACRPR_PWR_LOW);

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_reg_write(logic [14:0] a);
        wr_en && (wr_addr == a);
    endsequence

    a_reset_defaults: assert property (disable iff (1'b0)
        $rose(rstn) |-> (s.supply == ACRPR_RST_SUPPLY) &&
        (full_scale_range == ACRPR_RST_FSR) &&
        (power_mode_code_1 == ACRPR_PWR_HIGH))
        else $error("register defaults wrong after reset");
    a_clk_pecl_write: assert property (
        s_reg_write(ACRPR_OFS_CLK_IN) |=> sampling_clock_pecl_input_en ==
        $past(wr_data[ACRPR_BIT_CLK_PECL]))
        else $error("sampling clock pecl bit not updated");
    a_sref_pecl_write: assert property (
        s_reg_write(ACRPR_OFS_CLK_IN) |=> sync_ref_pecl_input_en ==
        $past(wr_data[ACRPR_BIT_SREF_PECL]))
        else $error("sync ref pecl bit not updated");
    a_sref_polarity: assert property (
        ##1 sync_ref_aligned == ($past(s.sref_s2) ^ $past(sync_ref_invert)))
        else $error("sync ref polarity wrong");
    a_analog_rail_write: assert property (
        s_reg_write(ACRPR_OFS_SUPPLY) |=> analog_rail_noise_suppress_en ==
        $past(wr_data[ACRPR_BIT_ANA_NS]))
        else $error("analog rail enable not updated");
    a_clock_rail_write: assert property (
        s_reg_write(ACRPR_OFS_SUPPLY) |=> clock_rail_noise_suppress_en ==
        $past(wr_data[ACRPR_BIT_CLK_NS]))
        else $error("clock rail enable not updated");
    // the edge after release still shows the reset word, so skip it
    a_edge_readonly: assert property (
        $past(rstn) |-> s.edge_pos == $past(sync_edge_position_in))
        else $error("edge position not from detector");
    a_fsr_high_write: assert property (
        s_reg_write(ACRPR_OFS_FSR_HI) |=> full_scale_range[15:8] ==
        $past(wr_data))
        else $error("range high byte not updated");
    a_power_low_write: assert property (
        s_reg_write(ACRPR_OFS_PWR1) ##0 (wr_data == ACRPR_PWR_LOW)
        |=> low_power_mode_active [*2])
        else $error("low power code not decoded");
    a_delay_sel_write: assert property (
        s_reg_write(ACRPR_OFS_SYNC_CTRL) |=> sync_delay_select ==
        $past(wr_data[3:0]))
        else $error("sync delay select not updated");

endmodule

// [rtl/acrpr_pkg.sv]
// constants, field layout and state record of the converter's clock,
// range and power register bank.
// assumes one core clock; the serial port pins are asynchronous to it.
package acrpr_pkg;

    localparam int unsigned ACRPR_ADDR_W = 15;

    // header: one direction bit, then a 15-bit byte address
    localparam logic [3:0] ACRPR_HDR_LAST = 4'hf;
    localparam logic [2:0] ACRPR_BYTE_LAST = 3'h7;
    localparam int unsigned ACRPR_HDR_RD_BIT = 14;

    // byte offsets
    localparam logic [14:0] ACRPR_OFS_SYNC_CTRL = 15'h0029;
    localparam logic [14:0] ACRPR_OFS_CLK_IN = 15'h002a;
    localparam logic [14:0] ACRPR_OFS_SUPPLY = 15'h002b;
    localparam logic [14:0] ACRPR_OFS_EDGE_B0 = 15'h002c;
    localparam logic [14:0] ACRPR_OFS_EDGE_B1 = 15'h002d;
    localparam logic [14:0] ACRPR_OFS_EDGE_B2 = 15'h002e;
    localparam logic [14:0] ACRPR_OFS_FSR_LO = 15'h0030;
    localparam logic [14:0] ACRPR_OFS_FSR_HI = 15'h0031;
    localparam logic [14:0] ACRPR_OFS_PWR1 = 15'h0037;

    // reset values
    localparam logic [7:0] ACRPR_RST_SYNC_CTRL = 8'h80;
    localparam logic [7:0] ACRPR_RST_CLK_IN = 8'h00;
    localparam logic [7:0] ACRPR_RST_SUPPLY = 8'h10;
    localparam logic [23:0] ACRPR_RST_EDGE = 24'h00_0000;
    localparam logic [15:0] ACRPR_RST_FSR = 16'ha000;
    localparam logic [7:0] ACRPR_RST_PWR1 = 8'h4b;

    // field positions
    localparam int unsigned ACRPR_SEL_MSB = 3;
    localparam int unsigned ACRPR_BIT_CLK_PECL = 2;
    localparam int unsigned ACRPR_BIT_SREF_PECL = 1;
    localparam int unsigned ACRPR_BIT_SREF_INV = 0;
    localparam int unsigned ACRPR_BIT_ANA_NS = 2;
    localparam int unsigned ACRPR_BIT_CLK_NS = 0;

    // power mode codes
    localparam logic [7:0] ACRPR_PWR_LOW = 8'h46;
    localparam logic [7:0] ACRPR_PWR_HIGH = 8'h4b;

    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        logic cs_n_s1;
        logic cs_n_s2;
        logic sdi_s1;
        logic sdi_s2;
        logic sref_s1;
        logic sref_s2;
        logic hdr_done;
        logic [3:0] hdr_cnt;
        logic [15:0] hdr_shift;
        logic [2:0] bit_cnt;
        logic rd;
        logic [14:0] addr;
        logic [7:0] in_shift;
        logic [7:0] out_shift;
        logic sdo;
        logic sdo_drive;
        logic [7:0] sync_ctrl;
        logic [7:0] clk_in;
        logic [7:0] supply;
        logic [23:0] edge_pos;
        logic [15:0] fsr;
        logic [7:0] pwr1;
        logic sref_aligned;
    } acrpr_state_s;

endpackage

// [test/acrpr_regs_tb_top.sv]
// self-checking bench for the clock, range and power register bank.
// assumes the bank is reached only through its mode-0 serial port.
`timescale 1ns/1ps
module acrpr_regs_tb_top;
    import acrpr_pkg::*;

    typedef struct {
        logic [14:0] a;
        logic [7:0] wd;
        logic [7:0] rd;
        int k;
        logic [15:0] exp;
    } acrpr_tb_row_s;

    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic spi_sclk = 1'b0;
    logic spi_cs_n = 1'b1;
    logic spi_sdi = 1'b0;
    logic spi_sdo;
    logic spi_sdo_oe_n;
    logic sync_ref_in = 1'b0;
    logic [23:0] edge_in = 24'h3c_5a96;
    logic samp_pecl, sref_pecl, sref_inv, sref_al, ana_ns, clk_ns, low_pwr;
    logic [3:0] dly_sel;
    logic [15:0] fsr;
    logic [7:0] pwr;
    logic [7:0] q;
    logic oe_seen;
    int fails = 0;
    int check_count = 0;

    acrpr_regs i_acrpr_regs (
        .core_clk(core_clk), .rstn(rstn), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
        .spi_sdo_oe_n(spi_sdo_oe_n), .sync_ref_in(sync_ref_in),
        .sync_edge_position_in(edge_in),
        .sampling_clock_pecl_input_en(samp_pecl),
        .sync_ref_pecl_input_en(sref_pecl), .sync_ref_invert(sref_inv),
        .sync_ref_aligned(sref_al), .analog_rail_noise_suppress_en(ana_ns),
        .clock_rail_noise_suppress_en(clk_ns), .sync_delay_select(dly_sel),
        .full_scale_range(fsr), .power_mode_code_1(pwr),
        .low_power_mode_active(low_pwr)
    );

    ////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one byte per frame; half periods of 6 clocks keep above the 5 clock
    // minimum the synchroniser needs
    task automatic spi_frame(input logic rd, input logic [14:0] a,
                             input logic [7:0] wd, output logic [7:0] qo);
        logic [23:0] sh;
        sh = {rd, a, wd};
        qo = 8'h00;
        @(posedge core_clk) spi_cs_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        for (int i = 23; i >= 0; i--) begin
            spi_sdi <= sh[i];
            repeat (6) @(posedge core_clk);
            spi_sclk <= 1'b1;
            if (i < 8) qo = {qo[6:0], spi_sdo};
            if (i == 0) oe_seen = spi_sdo_oe_n;
            repeat (6) @(posedge core_clk);
            spi_sclk <= 1'b0;
        end
        repeat (6) @(posedge core_clk);
        spi_cs_n <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask

    function automatic logic [15:0] pick(input int k);
        case (k)
            0: pick = {13'h0000, samp_pecl, sref_pecl, sref_inv};
            1: pick = {14'h0000, ana_ns, clk_ns};
            2: pick = {12'h0000, dly_sel};
            3: pick = fsr;
            default: pick = {pwr, 7'h00, low_pwr};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    acrpr_tb_row_s rows[15] = '{
        '{15'h002a, 8'h04, 8'h04, 0, 16'h0004},
        '{15'h002a, 8'h02, 8'h02, 0, 16'h0002},
        '{15'h002a, 8'h01, 8'h01, 0, 16'h0001},
        '{15'h002a, 8'h00, 8'h00, 0, 16'h0000},
        '{15'h002b, 8'h14, 8'h14, 1, 16'h0002},
        '{15'h002b, 8'h11, 8'h11, 1, 16'h0001},
        '{15'h0029, 8'h85, 8'h85, 2, 16'h0005},
        '{15'h0030, 8'h34, 8'h34, 3, 16'ha034},
        '{15'h0031, 8'h32, 8'h32, 3, 16'h3234},
        // rate taken as at most 1 GSPS; companions, calibration and link
        // enables live outside this bank and are assumed handled
        '{15'h0037, 8'h46, 8'h46, 4, 16'h4601},
        '{15'h0037, 8'h4b, 8'h4b, 4, 16'h4b00},
        '{15'h002c, 8'h55, 8'h96, 3, 16'h3234},
        '{15'h002d, 8'hff, 8'h5a, 3, 16'h3234},
        '{15'h002e, 8'h00, 8'h3c, 3, 16'h3234},
        '{15'h0040, 8'h77, 8'h00, 3, 16'h3234}
    };

    initial begin
        repeat (100000) @(posedge core_clk);
        fails++;
        end_sim();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (6) @(posedge core_clk);
        foreach (rows[i]) begin
            spi_frame(1'b0, rows[i].a, rows[i].wd, q);
            chk("port", {8'h00, rows[i].exp}, {8'h00, pick(rows[i].k)});
            chk("sdo idle wr", 24'h00_0001, {23'h00_0000, oe_seen});
            spi_frame(1'b1, rows[i].a, 8'h00, q);
            chk("readback", {16'h0000, rows[i].rd}, {16'h0000, q});
            chk("sdo enable", 24'h00_0000, {23'h00_0000, oe_seen});
            chk("sdo release", 24'h00_0001,
                {23'h00_0000, spi_sdo_oe_n});
            $display("row %0d done", i);
        end
        // mid-run reset must restore the clock input, supply, range and power defaults
        @(posedge core_clk) rstn <= 1'b0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk("clk in", 24'h00_0000, {8'h00, pick(0)});
        chk("rails", 24'h00_0000, {8'h00, pick(1)});
        chk("fsr", 24'h00_a000, {8'h00, pick(3)});
        chk("power", 24'h00_4b00, {8'h00, pick(4)});
        spi_frame(1'b1, ACRPR_OFS_SUPPLY, 8'h00, q);
        chk("supply rst", 24'h00_0010, {16'h0000, q});
        spi_frame(1'b1, ACRPR_OFS_FSR_HI, 8'h00, q);
        chk("fsr hi rst", 24'h00_00a0, {16'h0000, q});
        $display("reset test done");
        // polarity of the sync reference, 3 clock pipeline
        sync_ref_in <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk("aligned", 24'h00_0001, {23'h00_0000, sref_al});
        spi_frame(1'b0, ACRPR_OFS_CLK_IN, 8'h01, q);
        chk("aligned inv", 24'h00_0000, {23'h00_0000, sref_al});
        sync_ref_in <= 1'b0;
        repeat (5) @(posedge core_clk);
        chk("aligned inv0", 24'h00_0001, {23'h00_0000, sref_al});
        $display("sync test done");
        // status follows the detector live; delay picked from what is read
        edge_in <= 24'h81_c3e7;
        repeat (2) @(posedge core_clk);
        spi_frame(1'b1, ACRPR_OFS_EDGE_B0, 8'h00, q);
        chk("edge b0 live", 24'h00_00e7, {16'h0000, q});
        spi_frame(1'b0, ACRPR_OFS_SYNC_CTRL, {4'h8, q[3:0]}, q);
        chk("delay pick", 24'h00_0007, {20'h0_0000, dly_sel});
        spi_frame(1'b1, ACRPR_OFS_EDGE_B2, 8'h00, q);
        chk("edge b2 live", 24'h00_0081, {16'h0000, q});
        $display("edge select test done");
        end_sim();
    end
endmodule
